// *** logic/sfrtc_defines.vh ***
/*
 * shared constants of the serial flash read, transfer and compare front end:
 * opcodes, frame bit counts, geometry, status layout and timing.
 * assumes it is included by its bare name from the logic/ files.
 */
`ifndef SFRTC_DEFINES_VH
`define SFRTC_DEFINES_VH

// ======================================
// opcodes
`define SFRTC_OP_PAGE_RD 8'h52
`define SFRTC_OP_XFR_B1 8'h53
`define SFRTC_OP_BUF_RD_B1 8'h54
`define SFRTC_OP_XFR_B2 8'h55
`define SFRTC_OP_BUF_RD_B2 8'h56
`define SFRTC_OP_STATUS 8'h57
`define SFRTC_OP_CMP_B1 8'h60
`define SFRTC_OP_CMP_B2 8'h61

// ======================================
// frame bit counts (rising edges since chip select fell)
`define SFRTC_OPC_LAST 7'h07
`define SFRTC_ADDR_LAST 7'h1F
`define SFRTC_STAT_START 7'h08
`define SFRTC_BUF_START 7'h28
`define SFRTC_PAGE_START 7'h40

// ======================================
// geometry
`define SFRTC_PAGES 1024
`define SFRTC_PAGE_LAST 9'h107
`define SFRTC_PAGE_BYTES 19'h00108
`define SFRTC_BUF2_BASE 10'h108
`define SFRTC_PAGE_MSB 18
`define SFRTC_PAGE_LSB 9

// ======================================
// status byte layout
`define SFRTC_ST_READY 7
`define SFRTC_ST_CMP 6
`define SFRTC_DENSITY 3'h2

// ======================================
// timing
`define SFRTC_CLK_NS 50
`define SFRTC_XFR_NS 80000
`define SFRTC_XFR_CYC (`SFRTC_XFR_NS / `SFRTC_CLK_NS)

`endif

// *** logic/sfrtc_mem.v ***
/*
 * flip-flop storage with one write port and two combinational read ports.
 * assumes one clock; contents are not reset.
 */
`timescale 1ns/1ps
`default_nettype none

module sfrtc_mem #(
    parameter DEPTH = 528,
    parameter AW = 10,
    parameter DW = 8
) (
    input wire clk,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [DW-1:0] wr_data,
    input wire [AW-1:0] rd_a_addr,
    output wire [DW-1:0] rd_a_data,
    input wire [AW-1:0] rd_b_addr,
    output wire [DW-1:0] rd_b_data
);

    // ======================================
    // storage
    reg [DW-1:0] mem_reg [0:DEPTH-1]; // one word per entry

    // write on the clock edge
    always @(posedge clk)
    begin
        if (wr_en)
        begin
            mem_reg[wr_addr] <= wr_data;
        end
    end

    // two independent reads so a fetch never waits on an internal op
    assign rd_a_data = mem_reg[rd_a_addr];
    assign rd_b_data = mem_reg[rd_b_addr];

endmodule // sfrtc_mem

`default_nettype wire

// *** logic/sfrtc_fifo.v ***
/*
 * small synchronous fifo with valid/ready on both sides and a flush.
 * assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module sfrtc_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire clk,
    input wire srst,
    input wire flush,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);

    // ======================================
    // storage and pointers
    reg [WIDTH-1:0] fifo_reg [0:DEPTH-1]; // entries
    reg [AW-1:0] wr_ptr_reg; // next write slot
    reg [AW-1:0] rd_ptr_reg; // next read slot
    reg [AW:0] count_reg; // entries held

    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    assign in_ready = (count_reg < DEPTH);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data = fifo_reg[rd_ptr_reg];

    // pointer wrap assumes a power-of-two depth
    always @(posedge clk)
    begin
        if (srst | flush)
        begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                fifo_reg[wr_ptr_reg] <= in_data;
                wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop)
            begin
                rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            // push and pop together leave the count alone
            if (push & ~pop)
            begin
                count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
            end
            else if (pop & ~push)
            begin
                count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
            end
        end
    end

endmodule // sfrtc_fifo

`default_nettype wire

// *** logic/sfrtc_top.v ***
/*
 * serial flash command front end: spi slave framing, direct page read,
 * buffer read, page-to-buffer transfer and compare, status read.
 * assumes the serial pins are asynchronous to clk and are sampled at
 * 20 MHz; the serial clock must be well under a quarter of clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sfrtc_defines.vh"

module sfrtc_top #(
    parameter PAGE_COUNT = `SFRTC_PAGES,
    parameter [2:0] DENSITY_CODE = `SFRTC_DENSITY,
    parameter FIFO_DEPTH = 4
) (
    input wire clk,
    input wire srst,
    input wire spi_cs_n,
    input wire spi_sck,
    input wire spi_si,
    output wire spi_so,
    output wire spi_so_oe,
    output wire ready_out,
    input wire preload_en,
    input wire [18:0] preload_addr,
    input wire [7:0] preload_data
);

    // ======================================
    // local encodings
    localparam ST_IDLE = 1'b0; // no array operation
    localparam ST_RUN = 1'b1; // transfer or compare running
    localparam MODE_NONE = 2'h0; // output stays off
    localparam MODE_STAT = 2'h1; // status byte repeats
    localparam MODE_DATA = 2'h2; // bytes come from the fifo
    // kept unsized so the compare widens the counter instead of cutting the constant
    localparam XFR_LAST = `SFRTC_XFR_CYC - 1; // busy length, must stay below 4096

    // ======================================
    // pin synchronisers; [0] feeds only [1], [2] of chip select and serial clock is the edge history
    reg [2:0] cs_s_reg; // chip select
    reg [2:0] sck_s_reg; // serial clock
    reg [1:0] si_s_reg; // serial input

    always @(posedge clk)
    begin
        if (srst)
        begin
            cs_s_reg <= 3'h7;
            sck_s_reg <= 3'h0;
            si_s_reg <= 2'h0;
        end
        else
        begin
            cs_s_reg <= {cs_s_reg[1:0], spi_cs_n};
            sck_s_reg <= {sck_s_reg[1:0], spi_sck};
            si_s_reg <= {si_s_reg[0], spi_si};
        end
    end

    wire cs_high = cs_s_reg[1];
    wire cs_rise = cs_s_reg[1] & ~cs_s_reg[2];
    // sample on rising, launch on falling: valid for idle low or high
    wire sck_rise = sck_s_reg[1] & ~sck_s_reg[2];
    wire sck_fall = ~sck_s_reg[1] & sck_s_reg[2];
    wire si_bit = si_s_reg[1];

    // ======================================
    // state declarations
    reg [6:0] bit_cnt_reg; // rising edges in this frame, saturating
    reg [31:0] shift_reg; // incoming bits
    reg [7:0] opcode_reg; // captured opcode
    reg [1:0] mode_reg; // what the output phase sends
    reg [6:0] out_start_reg; // bit count where output begins
    reg [2:0] out_bit_reg; // bit within the outgoing byte
    reg [7:0] out_sh_reg; // rest of the outgoing byte
    reg so_reg; // serial output level
    reg so_oe_reg; // serial output enable
    reg fetch_act_reg; // prefetch running
    reg fetch_buf_reg; // prefetch reads a buffer, not the array
    reg fetch_sel_reg; // buffer two when set
    reg [18:0] fetch_base_reg; // array page base
    reg [8:0] fetch_ofs_reg; // byte within page or buffer
    reg pend_reg; // transfer or compare waiting for cs rise
    reg pend_cmp_reg; // pending op is a compare
    reg pend_sel_reg; // pending op targets buffer two
    reg [9:0] pend_page_reg; // pending page
    reg state_reg; // op state
    reg ready_reg; // mirrors idle for status and pin
    reg op_cmp_reg; // running op is a compare
    reg op_sel_reg; // running op buffer
    reg [18:0] op_base_reg; // running op page base
    reg [11:0] op_cnt_reg; // cycles into the op
    reg diff_reg; // mismatch seen so far
    reg cmp_res_reg; // last compare result

    wire [31:0] shift_next = {shift_reg[30:0], si_bit};
    wire [7:0] status_byte = {ready_reg, cmp_res_reg, DENSITY_CODE, 3'h0};

    // ======================================
    // storage: the main array in one block, both buffers in another
    wire [7:0] arr_a_data; // prefetch read
    wire [7:0] arr_b_data; // op read
    wire [7:0] buf_a_data; // prefetch read
    wire [7:0] buf_b_data; // compare read
    wire [9:0] fetch_buf_base = fetch_sel_reg ? `SFRTC_BUF2_BASE : 10'h000;
    wire [9:0] op_buf_base = op_sel_reg ? `SFRTC_BUF2_BASE : 10'h000;
    wire op_in_page = (op_cnt_reg[11:9] == 3'h0) && (op_cnt_reg[8:0] <= `SFRTC_PAGE_LAST);
    wire op_wr = (state_reg == ST_RUN) & ~op_cmp_reg & op_in_page;

    // array is sized by page count; only the preload port writes it
    sfrtc_mem #(.DEPTH(PAGE_COUNT * 264), .AW(19), .DW(8)) u_array (
        .clk(clk),
        .wr_en(preload_en),
        .wr_addr(preload_addr),
        .wr_data(preload_data),
        .rd_a_addr(fetch_base_reg + {10'h000, fetch_ofs_reg}),
        .rd_a_data(arr_a_data),
        .rd_b_addr(op_base_reg + {10'h000, op_cnt_reg[8:0]}),
        .rd_b_data(arr_b_data)
    );

    sfrtc_mem #(.DEPTH(528), .AW(10), .DW(8)) u_bufs (
        .clk(clk),
        .wr_en(op_wr),
        .wr_addr(op_buf_base + {1'b0, op_cnt_reg[8:0]}),
        .wr_data(arr_b_data),
        .rd_a_addr(fetch_buf_base + {1'b0, fetch_ofs_reg}),
        .rd_a_data(buf_a_data),
        .rd_b_addr(op_buf_base + {1'b0, op_cnt_reg[8:0]}),
        .rd_b_data(buf_b_data)
    );

    // ======================================
    // read fifo between the storage and the output shifter
    wire fifo_in_ready; // stalls the prefetch when full
    wire fifo_out_valid; // a byte is ready to send
    wire [7:0] fifo_out_data; // byte to send
    // page read data never touches the buffers
    wire [7:0] fetch_data = fetch_buf_reg ? buf_a_data : arr_a_data;
    wire launch = sck_fall & ~cs_high & (mode_reg != MODE_NONE) & (bit_cnt_reg >= out_start_reg);
    wire byte_start = launch & (out_bit_reg == 3'h0);
    wire fifo_pop = byte_start & (mode_reg == MODE_DATA);

    sfrtc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(2)) u_fifo (
        .clk(clk),
        .srst(srst),
        .flush(cs_high),
        .in_valid(fetch_act_reg),
        .in_ready(fifo_in_ready),
        .in_data(fetch_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // ======================================
    // command shifter and decode
    always @(posedge clk)
    begin
        if (srst | cs_high)
        begin
            // idle chip select clears the frame; sck is ignored
            bit_cnt_reg <= 7'h00;
            shift_reg <= 32'h0;
            opcode_reg <= 8'h00;
            mode_reg <= MODE_NONE;
            out_start_reg <= 7'h7F;
            fetch_act_reg <= 1'b0;
            fetch_buf_reg <= 1'b0;
            fetch_sel_reg <= 1'b0;
            fetch_base_reg <= 19'h0;
            fetch_ofs_reg <= 9'h000;
        end
        else
        begin
            if (sck_rise)
            begin
                shift_reg <= shift_next;
                if (bit_cnt_reg != 7'h7F)
                begin
                    bit_cnt_reg <= bit_cnt_reg + 7'h01;
                end
                if (bit_cnt_reg == `SFRTC_OPC_LAST)
                begin
                    opcode_reg <= shift_next[7:0];
                    if (shift_next[7:0] == `SFRTC_OP_STATUS)
                    begin
                        mode_reg <= MODE_STAT;
                        out_start_reg <= `SFRTC_STAT_START;
                    end
                end
                if (bit_cnt_reg == `SFRTC_ADDR_LAST)
                begin
                    // page field skips five reserved bits, byte field is last
                    fetch_base_reg <= shift_next[`SFRTC_PAGE_MSB:`SFRTC_PAGE_LSB] * `SFRTC_PAGE_BYTES;
                    fetch_ofs_reg <= shift_next[8:0];
                    if ((opcode_reg == `SFRTC_OP_PAGE_RD) && ready_reg)
                    begin
                        fetch_act_reg <= 1'b1;
                        fetch_buf_reg <= 1'b0;
                        mode_reg <= MODE_DATA;
                        out_start_reg <= `SFRTC_PAGE_START;
                    end
                    else if ((opcode_reg == `SFRTC_OP_BUF_RD_B1) || (opcode_reg == `SFRTC_OP_BUF_RD_B2))
                    begin
                        // buffer reads are allowed while busy
                        fetch_act_reg <= 1'b1;
                        fetch_buf_reg <= 1'b1;
                        fetch_sel_reg <= opcode_reg[1];
                        mode_reg <= MODE_DATA;
                        out_start_reg <= `SFRTC_BUF_START;
                    end
                end
            end
            // prefetch pushes until the fifo is full
            if (fetch_act_reg & fifo_in_ready)
            begin
                if (fetch_ofs_reg >= `SFRTC_PAGE_LAST)
                begin
                    fetch_ofs_reg <= 9'h000;
                end
                else
                begin
                    fetch_ofs_reg <= fetch_ofs_reg + 9'h001;
                end
            end
        end
    end

    // ======================================
    // output shifter
    always @(posedge clk)
    begin
        if (srst | cs_high)
        begin
            // rising chip select ends any read and releases the pin
            so_oe_reg <= 1'b0;
            so_reg <= 1'b0;
            out_bit_reg <= 3'h0;
            out_sh_reg <= 8'h00;
        end
        else if (launch)
        begin
            so_oe_reg <= 1'b1;
            out_bit_reg <= out_bit_reg + 3'h1;
            if (byte_start)
            begin
                // status is re-read at each byte so it stays current
                if (mode_reg == MODE_STAT)
                begin
                    so_reg <= status_byte[7];
                    out_sh_reg <= {status_byte[6:0], 1'b0};
                end
                else
                begin
                    // an empty fifo sends ones rather than stale data
                    so_reg <= fifo_out_valid ? fifo_out_data[7] : 1'b1;
                    out_sh_reg <= fifo_out_valid ? {fifo_out_data[6:0], 1'b0} : 8'hFE;
                end
            end
            else
            begin
                so_reg <= out_sh_reg[7];
                out_sh_reg <= {out_sh_reg[6:0], 1'b0};
            end
        end
    end

    // ======================================
    // pending array command, armed by the address and fired by cs rise
    always @(posedge clk)
    begin
        if (srst)
        begin
            pend_reg <= 1'b0;
            pend_cmp_reg <= 1'b0;
            pend_sel_reg <= 1'b0;
            pend_page_reg <= 10'h000;
        end
        else if (cs_high)
        begin
            pend_reg <= 1'b0;
        end
        else if (sck_rise && (bit_cnt_reg == `SFRTC_ADDR_LAST))
        begin
            pend_page_reg <= shift_next[`SFRTC_PAGE_MSB:`SFRTC_PAGE_LSB];
            case (opcode_reg)
                `SFRTC_OP_XFR_B1, `SFRTC_OP_XFR_B2:
                begin
                    pend_reg <= 1'b1;
                    pend_cmp_reg <= 1'b0;
                    pend_sel_reg <= (opcode_reg == `SFRTC_OP_XFR_B2);
                end
                `SFRTC_OP_CMP_B1, `SFRTC_OP_CMP_B2:
                begin
                    pend_reg <= 1'b1;
                    pend_cmp_reg <= 1'b1;
                    pend_sel_reg <= opcode_reg[0];
                end
                default:
                begin
                    pend_reg <= 1'b0;
                end
            endcase
        end
    end

    // ======================================
    // self-timed transfer and compare
    always @(posedge clk)
    begin
        if (srst)
        begin
            state_reg <= ST_IDLE;
            ready_reg <= 1'b1;
            op_cmp_reg <= 1'b0;
            op_sel_reg <= 1'b0;
            op_base_reg <= 19'h0;
            op_cnt_reg <= 12'h000;
            diff_reg <= 1'b0;
            cmp_res_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    // a command arriving while busy is dropped
                    if (cs_rise & pend_reg)
                    begin
                        state_reg <= ST_RUN;
                        ready_reg <= 1'b0;
                        op_cmp_reg <= pend_cmp_reg;
                        op_sel_reg <= pend_sel_reg;
                        op_base_reg <= pend_page_reg * `SFRTC_PAGE_BYTES;
                        op_cnt_reg <= 12'h000;
                        diff_reg <= 1'b0;
                    end
                end
                ST_RUN:
                begin
                    // one byte per cycle, then hold busy for the full time
                    op_cnt_reg <= op_cnt_reg + 12'h001;
                    if (op_cmp_reg & op_in_page & (arr_b_data != buf_b_data))
                    begin
                        diff_reg <= 1'b1;
                    end
                    if (op_cnt_reg == XFR_LAST)
                    begin
                        state_reg <= ST_IDLE;
                        ready_reg <= 1'b1;
                        if (op_cmp_reg)
                        begin
                            cmp_res_reg <= diff_reg;
                        end
                    end
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                    ready_reg <= 1'b1;
                end
            endcase
        end
    end

    // ======================================
    // outputs, each straight from a flop
    assign spi_so = so_reg;
    assign spi_so_oe = so_oe_reg;
    assign ready_out = ready_reg;

endmodule // sfrtc_top

`default_nettype wire

// *** tb/sfrtc_top_sva.sv ***
/*
 * timing checker for the serial flash front end, bound to its top ports.
 * assumes one clock domain and the synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module sfrtc_top_sva (
    input wire logic clk,
    input wire logic srst,
    input wire logic spi_cs_n,
    input wire logic spi_sck,
    input wire logic spi_si,
    input wire logic spi_so,
    input wire logic spi_so_oe,
    input wire logic ready_out,
    input wire logic preload_en,
    input wire logic [18:0] preload_addr,
    input wire logic [7:0] preload_data
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    // ======================================
    // busy length counter
    int busy_cnt; // cycles with ready low, cleared while ready
    always_ff @(posedge clk)
    begin
        if (srst || ready_out)
            busy_cnt <= 0;
        else
            busy_cnt <= busy_cnt + 1;
    end

    // ======================================
    // sequences and properties
    sequence cs_release;
        $rose(spi_cs_n) ##1 spi_cs_n;
    endsequence
    sequence cs_high3;
        spi_cs_n [*3];
    endsequence

    oe_off_cs_a: assert property (cs_release |-> ##[0:4] !spi_so_oe)
        else $error("output still enabled after select release");
    idle_no_oe_a: assert property (cs_high3 ##1 cs_high3 |-> !spi_so_oe)
        else $error("output enabled while deselected");
    oe_hold_a: assert property (spi_so_oe && !spi_cs_n |=> spi_so_oe)
        else $error("output dropped inside a frame");
    oe_cs_low_a: assert property ($rose(spi_so_oe) |-> !spi_cs_n && !$past(spi_cs_n, 2))
        else $error("output enabled without a frame");
    so_after_fall_a: assert property (spi_so_oe && $changed(spi_so) |-> !$past(spi_sck) && !$past(spi_sck, 2))
        else $error("output changed outside the low clock phase");
    busy_start_a: assert property ($fell(ready_out) |-> spi_cs_n && $past(spi_cs_n, 2))
        else $error("busy began before select release");
    busy_len_a: assert property ($rose(ready_out) |-> busy_cnt inside {[1599:1601]})
        else $error("busy time wrong");
    reset_ready_a: assert property ($fell(srst) |-> ready_out && !spi_so_oe && !spi_so)
        else $error("not ready after reset");
endmodule // sfrtc_top_sva

bind sfrtc_top sfrtc_top_sva sfrtc_top_sva_i (.clk(clk), .srst(srst), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
    .spi_si(spi_si), .spi_so(spi_so), .spi_so_oe(spi_so_oe), .ready_out(ready_out), .preload_en(preload_en),
    .preload_addr(preload_addr), .preload_data(preload_data));

`default_nettype wire

// *** tb/sfrtc_host.sv ***
/*
 * host spi master model, modes 0 and 3, 400 ns serial clock.
 * assumes changes are made 1 ns after a 50 ns clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module sfrtc_host (
    input wire logic clk,
    output logic cs_n,
    output logic sck,
    output logic si,
    input wire logic so,
    input wire logic so_oe
);
    logic [31:0] rx; // bytes read, newest in the low bits
    logic oe_bad; // output found disabled when sampled

    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end

    // half a serial clock: four system clocks
    task automatic half();
        repeat (4) @(posedge clk);
        #1;
    endtask

    // ======================================
    // one framed transfer: header bits, then bytes read back
    task automatic frame(input logic [63:0] hdr, input int nhdr, input int nbytes, input logic mode3);
        int i;
        @(posedge clk);
        #1;
        // idle level settles while still deselected, so no false edge opens the frame
        sck = mode3; // idle level picks the mode
        half();
        cs_n = 1'b0; // frame opens
        rx = '0;
        oe_bad = 1'b0;
        half();
        for (i = 0; i < nhdr + 8 * nbytes; i++)
        begin
            sck = 1'b0;
            si = (i < nhdr) ? hdr[63 - i] : ~si; // msb first, idle bits toggle
            half();
            sck = 1'b1;
            if (i >= nhdr)
            begin
                rx = {rx[30:0], so}; // sample on rise
                oe_bad = oe_bad | !so_oe;
            end
            half();
        end
        sck = mode3;
        half();
        cs_n = 1'b1; // low held through the whole frame
        si = ~si;
        half();
        half();
    endtask
endmodule // sfrtc_host

`default_nettype wire

// *** tb/sfrtc_top_test.sv ***
/*
 * self-checking bench for the serial flash front end.
 * assumes the host model and the bound checker are compiled alongside.
 */
`timescale 1ns/1ps
`default_nettype none

module sfrtc_top_test;
    logic clk = 1'b0; // 20 MHz system clock
    logic srst = 1'b1; // reset held at start
    logic preload_en = 1'b0;
    logic [18:0] preload_addr = '0;
    logic [7:0] preload_data = '0;
    wire cs_n, sck, si, so, so_oe, ready_out;
    int error_cnt = 0;
    int n_checks = 0;
    int p, b;

    always #25 clk = ~clk;

    sfrtc_host sfrtc_host_i (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe));
    sfrtc_top sfrtc_top_i (.clk(clk), .srst(srst), .spi_cs_n(cs_n), .spi_sck(sck), .spi_si(si),
        .spi_so(so), .spi_so_oe(so_oe), .ready_out(ready_out), .preload_en(preload_en),
        .preload_addr(preload_addr), .preload_data(preload_data));

    // ======================================
    // helpers
    function automatic logic [7:0] pat(input int pg, input int bt);
        return 8'(pg * 13 + bt);
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // frame, then output must be enabled in data phase and released after
    task automatic run(input logic [63:0] hdr, input int nhdr, input int nbytes, input logic mode3);
        sfrtc_host_i.frame(hdr, nhdr, nbytes, mode3);
        check({31'h0, sfrtc_host_i.oe_bad}, 32'h0);
        check({31'h0, so_oe}, 32'h0);
    endtask

    task automatic wait_ready();
        int k;
        for (k = 0; k < 2000 && ready_out !== 1'b1; k++)
            #50;
        if (ready_out !== 1'b1)
        begin
            error_cnt++;
            $display("ERROR t=%0t busy never ended", $time);
            end_of_test();
        end
    endtask

    // ======================================
    // scenarios
    task automatic t_status();
        run({8'h57, 56'h0}, 8, 2, 1'b0);
        check(sfrtc_host_i.rx[15:0], 16'h9090);
    endtask

    // transfer or compare: busy status while running, final status after
    task automatic t_array_op(input logic [7:0] op, input int pg, input logic [7:0] busy_st, input logic [7:0] done_st);
        run({op, 5'h0, 10'(pg), 9'h0, 32'h0}, 32, 0, 1'b0);
        check({31'h0, ready_out}, 32'h0);
        run({8'h57, 56'h0}, 8, 1, 1'b0);
        check(sfrtc_host_i.rx[7:0], busy_st);
        wait_ready();
        run({8'h57, 56'h0}, 8, 1, 1'b1);
        check(sfrtc_host_i.rx[7:0], done_st);
    endtask

    task automatic t_page_read();
        run({8'h52, 5'h1F, 10'd5, 9'd262, 32'hFFFF0000}, 64, 4, 1'b1);
        check(sfrtc_host_i.rx, {pat(5, 262), pat(5, 263), pat(5, 0), pat(5, 1)});
    endtask

    task automatic t_buf_read(input logic [7:0] op, input int pg);
        run({op, 15'h7FFF, 9'd263, 32'h0}, 40, 2, 1'b0);
        check(sfrtc_host_i.rx[15:0], {pat(pg, 263), pat(pg, 0)});
    endtask

    // ======================================
    // main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        #1;
        srst = 1'b0;
        for (p = 5; p < 7; p++)
            for (b = 0; b < 264; b++)
            begin
                preload_addr = 19'(p * 264 + b);
                preload_data = pat(p, b);
                preload_en = 1'b1;
                @(posedge clk);
                #1;
            end
        preload_en = 1'b0;
        t_status();
        t_array_op(8'h53, 5, 8'h10, 8'h90);
        t_array_op(8'h55, 6, 8'h10, 8'h90);
        t_page_read();
        t_buf_read(8'h54, 5);
        t_buf_read(8'h56, 6);
        t_array_op(8'h60, 5, 8'h10, 8'h90);
        t_array_op(8'h60, 6, 8'h10, 8'hD0);
        t_array_op(8'h61, 6, 8'h50, 8'h90);
        end_of_test();
    end
endmodule // sfrtc_top_test

`default_nettype wire
